// >>> hdl/acquisition_trigger_logic.sv
// trigger qualification and acquisition arming with an APB register file
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_logic
    import trig_pkg::*;
#(
    parameter int AUTO_CYCLES = AUTO_WAIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [SMP_W-1:0] analog_input_one,
    input wire logic [SMP_W-1:0] analog_input_two,
    input wire logic [SMP_W-1:0] analog_input_three,
    input wire logic [SMP_W-1:0] analog_input_four,
    input wire logic external_trigger_pin,
    input wire logic mains_reference_source,
    input wire logic acq_rearm,
    output logic trig_pulse,
    output logic trig_internal,
    output logic armed
);
    localparam int AUTO_W = $clog2(AUTO_CYCLES + 1);
    localparam logic [AUTO_W-1:0] AUTO_LAST = AUTO_W'(AUTO_CYCLES - 1);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [23:0] lvl;
        logic [CNT_W-1:0] wid;
        logic [CNT_W-1:0] dly;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] dcnt;
        logic [AUTO_W-1:0] acnt;
        dly_state_t dst;
        logic armed;
        logic trig_flag;
        logic auto_flag;
        logic pulse;
        logic internal;
        logic [1:0] alt;
        logic hi_p;
        logic ab_p;
        logic bl_p;
        logic ext_p;
        logic pos_arm;
        logic neg_arm;
        logic [31:0] prdata;
    } state_t;

    localparam state_t Q_RST = '{
        ctrl: CTRL_RST, lvl: LEVEL_RST, wid: WIDTH_RST, dly: DELAY_RST,
        dst: DS_IDLE, armed: ARMED_RST, default: '0};

    state_t q;
    state_t n;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic rel_ok(input logic [1:0] rel,
        input logic [CNT_W-1:0] meas, input logic [CNT_W-1:0] prog);
        logic r;
        unique case (rel)
            2'h0: r = meas > prog;
            2'h1: r = meas < prog;
            2'h2: r = meas == prog;
            2'h3: r = meas != prog;
        endcase
        return r;
    endfunction

    function automatic logic addr_known(input logic [APB_AW-1:0] a);
        return a == OFS_CTRL || a == OFS_LEVEL || a == OFS_WIDTH ||
            a == OFS_DELAY || a == OFS_CMD || a == OFS_STATUS;
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        return (&c) ? c : c + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins, source selection and level comparison

    logic ext_s;
    logic mains_s;
    trig_src_if src ();

    bit_sync u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(external_trigger_pin),
        .level(ext_s)
    );

    bit_sync u_mains_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(mains_reference_source),
        .level(mains_s)
    );

    trig_src_pick u_pick (
        .pclk(pclk),
        .presetn(presetn),
        .src(src)
    );

    trig_type_t ttype;
    trig_mode_t mode;
    logic [2:0] src_cfg;
    logic [2:0] eff_sel;
    logic slope;
    logic [1:0] rel;
    logic [1:0] runt_sel;
    logic by_event;

    assign ttype = trig_type_t'(q.ctrl[CTRL_TYPE_LSB +: 3]);
    assign mode = trig_mode_t'(q.ctrl[CTRL_MODE_LSB +: 2]);
    assign src_cfg = q.ctrl[CTRL_SRC_LSB +: 3];
    assign slope = q.ctrl[CTRL_SLOPE_BIT];
    assign rel = q.ctrl[CTRL_REL_LSB +: 2];
    assign runt_sel = q.ctrl[CTRL_RUNT_LSB +: 2];
    assign by_event = q.ctrl[CTRL_BYEVT_BIT];
    // alternate walks the four channels, one step per trigger
    assign eff_sel = (src_cfg == SRC_ALT) ? {1'b0, q.alt} : src_cfg;

    assign src.samples = {analog_input_four, analog_input_three,
        analog_input_two, analog_input_one};
    assign src.ext_lvl = ext_s;
    assign src.mains_lvl = mains_s;
    assign src.sel = eff_sel;
    assign src.level = q.lvl[LVL_TRIG_LSB +: SMP_W];
    assign src.lo_thr = q.lvl[LVL_LO_LSB +: SMP_W];
    assign src.hi_thr = q.lvl[LVL_HI_LSB +: SMP_W];

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic hi;
    logic ab;
    logic bl;
    logic rise;
    logic fall;
    logic edge_evt;
    logic pos_set;
    logic neg_set;
    logic dly_evt;
    logic real_evt;
    logic fire;
    logic auto_fire;
    logic lvl_match;
    logic wr;

    always_comb begin
        n = q;
        hi = src.is_hi;
        ab = src.is_above;
        bl = src.is_below;
        rise = hi & ~q.hi_p;
        fall = ~hi & q.hi_p;
        edge_evt = slope ? fall : rise;
        pos_set = ~bl & q.bl_p & ~ab;
        neg_set = ~ab & q.ab_p & ~bl;
        dly_evt = ext_s & ~q.ext_p;
        real_evt = 1'b0;
        fire = 1'b0;
        auto_fire = 1'b0;
        lvl_match = 1'b0;
        wr = psel & penable & pwrite;

        n.hi_p = hi;
        n.ab_p = ab;
        n.bl_p = bl;
        n.ext_p = ext_s;
        // an excursion is open between leaving one threshold and a return
        if (ab || bl) begin
            n.pos_arm = 1'b0;
            n.neg_arm = 1'b0;
        end
        if (pos_set) begin
            n.pos_arm = 1'b1;
        end
        if (neg_set) begin
            n.neg_arm = 1'b1;
        end

        // register writes come first so that a trigger in the same
        // cycle still sets its flag over a software clear
        if (psel && !penable) begin
            n.prdata = '0;
            unique case (paddr)
                OFS_CTRL: n.prdata[CTRL_W-1:0] = q.ctrl;
                OFS_LEVEL: n.prdata[23:0] = q.lvl;
                OFS_WIDTH: n.prdata[CNT_W-1:0] = q.wid;
                OFS_DELAY: n.prdata[CNT_W-1:0] = q.dly;
                OFS_STATUS: begin
                    n.prdata[STAT_ARMED_BIT] = q.armed;
                    n.prdata[STAT_TRIG_BIT] = q.trig_flag;
                    n.prdata[STAT_AUTO_BIT] = q.auto_flag;
                    n.prdata[STAT_SRC_LSB +: 3] = eff_sel;
                end
                default: n.prdata = '0;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: n.ctrl = pwdata[CTRL_W-1:0];
                OFS_LEVEL: n.lvl = pwdata[23:0];
                OFS_WIDTH: n.wid = pwdata[CNT_W-1:0];
                OFS_DELAY: n.dly = pwdata[CNT_W-1:0];
                OFS_CMD: begin
                    if (pwdata[CMD_ARM_BIT]) begin
                        n.armed = 1'b1;
                    end
                    if (pwdata[CMD_CLR_BIT]) begin
                        n.trig_flag = 1'b0;
                    end
                end
                default: n.armed = n.armed;
            endcase
        end

        // shared measuring counter; only the active type uses it
        unique case (ttype)
            TT_EDGE: real_evt = edge_evt;
            TT_DELAY: real_evt = 1'b0;
            TT_WIDTH: begin
                n.cnt = edge_evt ? CNT_W'(1) : sat_inc(q.cnt);
                if (slope ? rise : fall) begin
                    real_evt = rel_ok(rel, q.cnt, q.wid);
                end
            end
            TT_VIDEO: begin
                n.cnt = (bl && !q.bl_p) ? CNT_W'(1) : sat_inc(q.cnt);
                if (!bl && q.bl_p) begin
                    // a long sync marks a field, a short one a line
                    unique case (rel)
                        2'h0: real_evt = q.cnt > q.wid;
                        2'h1: real_evt = q.cnt <= q.wid;
                        default: real_evt = 1'b1;
                    endcase
                end
            end
            TT_RUNT: begin
                if (runt_sel != 2'h1 && q.pos_arm && bl && !q.bl_p) begin
                    real_evt = 1'b1;
                end
                if (runt_sel != 2'h0 && q.neg_arm && ab && !q.ab_p) begin
                    real_evt = 1'b1;
                end
            end
            TT_SLEW: begin
                n.cnt = (slope ? neg_set : pos_set) ? CNT_W'(1) :
                    sat_inc(q.cnt);
                if (!slope && (q.pos_arm || q.bl_p) && ab && !q.ab_p) begin
                    real_evt = rel_ok(rel, q.bl_p ? '0 : q.cnt, q.wid);
                end
                if (slope && (q.neg_arm || q.ab_p) && bl && !q.bl_p) begin
                    real_evt = rel_ok(rel, q.ab_p ? '0 : q.cnt, q.wid);
                end
            end
            TT_TIMEOUT: begin
                n.cnt = (rise || fall) ? CNT_W'(1) : sat_inc(q.cnt);
                unique case (rel)
                    2'h0: lvl_match = hi;
                    2'h1: lvl_match = ~hi;
                    default: lvl_match = 1'b1;
                endcase
                if (!rise && !fall && lvl_match && q.cnt == q.wid) begin
                    real_evt = 1'b1;
                end
            end
            default: real_evt = 1'b0;
        endcase

        // delay sequencer holds the edge trigger off
        if (ttype != TT_DELAY) begin
            n.dst = DS_IDLE;
        end else begin
            unique case (q.dst)
                DS_IDLE: begin
                    if (dly_evt) begin
                        n.dcnt = by_event ? CNT_W'(1) : '0;
                        n.dst = DS_COUNT;
                    end
                end
                DS_COUNT: begin
                    if (q.dcnt >= q.dly) begin
                        n.dst = DS_OPEN;
                    end else if (!by_event || dly_evt) begin
                        n.dcnt = q.dcnt + 1'b1;
                    end
                end
                DS_OPEN: begin
                    if (edge_evt) begin
                        real_evt = 1'b1;
                        n.dst = DS_IDLE;
                    end
                end
            endcase
        end

        // arming and modes
        if (mode != MD_SINGLE && acq_rearm) begin
            n.armed = 1'b1;
        end
        if (!q.armed || real_evt || mode != MD_AUTO) begin
            n.acnt = '0;
        end else begin
            n.acnt = q.acnt + 1'b1;
        end
        if (q.armed) begin
            if (real_evt) begin
                fire = 1'b1;
            end else if (mode == MD_AUTO && q.acnt == AUTO_LAST) begin
                fire = 1'b1;
                auto_fire = 1'b1;
            end
        end
        n.pulse = fire;
        n.internal = auto_fire;
        if (fire) begin
            n.armed = 1'b0;
            n.trig_flag = 1'b1;
            n.auto_flag = auto_fire;
            if (src_cfg == SRC_ALT) begin
                n.alt = q.alt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= Q_RST;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states: read data was latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);
    assign prdata = q.prdata;
    assign trig_pulse = q.pulse;
    assign trig_internal = q.internal;
    assign armed = q.armed;
endmodule
`default_nettype wire

// >>> hdl/bit_sync.sv
// two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_t;
    sync_t q;
    sync_t d;

    always_comb begin
        d = q;
        d.meta = pin;
        d.sync = q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.sync;
endmodule
`default_nettype wire

// >>> hdl/trig_src_pick.sv
// source picker: selects one input and compares a channel with the levels; a pin passes its level through
`timescale 1ns/1ps
`default_nettype none
module trig_src_pick
    import trig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    trig_src_if.picker src
);
    typedef struct packed {
        logic hi;
        logic above;
        logic below;
    } pick_t;
    pick_t q;
    pick_t d;

    always_comb begin
        d = '0;
        if (!src.sel[2]) begin
            d.hi = src.samples[src.sel[1:0]] >= src.level;
            d.above = src.samples[src.sel[1:0]] >= src.hi_thr;
            d.below = src.samples[src.sel[1:0]] <= src.lo_thr;
        end else if (src.sel == SRC_EXT) begin
            d.hi = src.ext_lvl;
            d.above = src.ext_lvl;
            d.below = ~src.ext_lvl;
        end else if (src.sel == SRC_MAINS) begin
            d.hi = src.mains_lvl;
            d.above = src.mains_lvl;
            d.below = ~src.mains_lvl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign src.is_hi = q.hi;
    assign src.is_above = q.above;
    assign src.is_below = q.below;
endmodule
`default_nettype wire

// >>> inc/trig_pkg.sv
// shared constants, register layout and enumerations of the trigger block
package trig_pkg;
    localparam int SMP_W = 8;
    localparam int CNT_W = 24;
    localparam int CTRL_W = 14;
    localparam int APB_AW = 8;

    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_LEVEL = 8'h04;
    localparam logic [APB_AW-1:0] OFS_WIDTH = 8'h08;
    localparam logic [APB_AW-1:0] OFS_DELAY = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_CMD = 8'h10;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h14;

    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_SRC_LSB = 3;
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_SLOPE_BIT = 8;
    localparam int CTRL_REL_LSB = 9;
    localparam int CTRL_BYEVT_BIT = 11;
    localparam int CTRL_RUNT_LSB = 12;
    localparam int LVL_TRIG_LSB = 0;
    localparam int LVL_LO_LSB = 8;
    localparam int LVL_HI_LSB = 16;
    localparam int CMD_ARM_BIT = 0;
    localparam int CMD_CLR_BIT = 1;
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_TRIG_BIT = 1;
    localparam int STAT_AUTO_BIT = 2;
    localparam int STAT_SRC_LSB = 3;

    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic [23:0] LEVEL_RST = 24'hC04080;
    localparam logic [CNT_W-1:0] WIDTH_RST = 24'h000010;
    localparam logic [CNT_W-1:0] DELAY_RST = 24'h000010;
    localparam logic ARMED_RST = 1'b1;

    localparam logic [2:0] SRC_EXT = 3'h4;
    localparam logic [2:0] SRC_MAINS = 3'h5;
    localparam logic [2:0] SRC_ALT = 3'h6;

    localparam int CLK_PERIOD_NS = 10;
    localparam int AUTO_WAIT_NS = 100000;
    localparam int AUTO_WAIT_CYC = AUTO_WAIT_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        TT_EDGE, TT_DELAY, TT_WIDTH, TT_VIDEO, TT_RUNT, TT_SLEW, TT_TIMEOUT
    } trig_type_t;
    typedef enum logic [1:0] {MD_AUTO, MD_NORMAL, MD_SINGLE} trig_mode_t;
    typedef enum logic [1:0] {DS_IDLE, DS_COUNT, DS_OPEN} dly_state_t;
endpackage

// >>> inc/trig_src_if.sv
// carrier between the trigger core and its source picker
`timescale 1ns/1ps
`default_nettype none
interface trig_src_if;
    import trig_pkg::*;
    logic [3:0][SMP_W-1:0] samples;
    logic ext_lvl;
    logic mains_lvl;
    logic [2:0] sel;
    logic [SMP_W-1:0] level;
    logic [SMP_W-1:0] hi_thr;
    logic [SMP_W-1:0] lo_thr;
    logic is_hi;
    logic is_above;
    logic is_below;
    modport picker(input samples, ext_lvl, mains_lvl, sel, level, hi_thr,
        lo_thr, output is_hi, is_above, is_below);
    modport user(output samples, ext_lvl, mains_lvl, sel, level, hi_thr,
        lo_thr, input is_hi, is_above, is_below);
endinterface
`default_nettype wire

// >>> tb/acquisition_trigger_logic_assertions.sv
// concurrent checks on the trigger block ports
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_logic_assertions
    import trig_pkg::*;
#(
    parameter int AUTO_CYCLES = AUTO_WAIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic acq_rearm,
    input wire logic trig_pulse,
    input wire logic trig_internal,
    input wire logic armed
);
    // slack covers the register and picker stages
    localparam int LIM = AUTO_CYCLES + 4;
    logic ctrl_wr, arm_wr, cmd_wr, bad_addr;
    logic [1:0] mode_q;
    int wait_q;
    assign ctrl_wr = psel && penable && pwrite && paddr == OFS_CTRL;
    assign cmd_wr = psel && penable && pwrite && paddr == OFS_CMD;
    assign arm_wr = cmd_wr && pwdata[CMD_ARM_BIT];
    assign bad_addr = paddr > OFS_STATUS || paddr[1:0] != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            wait_q <= 0;
        end else begin
            if (ctrl_wr)
                mode_q <= pwdata[CTRL_MODE_LSB +: 2];
            if (!armed || trig_pulse || ctrl_wr || cmd_wr || acq_rearm ||
                mode_q != MD_AUTO)
                wait_q <= 0;
            else
                wait_q <= wait_q + 1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pulse_single: assert property (trig_pulse |=> !trig_pulse)
        else $error("trigger pulse longer than one cycle");
    chk_armed_drops: assert property (trig_pulse |-> !armed)
        else $error("armed still high with trigger");
    chk_needs_arm: assert property (trig_pulse |-> $past(armed))
        else $error("trigger while not armed");
    chk_internal_paired: assert property (trig_internal |-> trig_pulse)
        else $error("internal flag without trigger");
    chk_normal_no_int: assert property (
        mode_q == MD_NORMAL && $past(mode_q) == MD_NORMAL |-> !trig_internal)
        else $error("internal trigger in normal mode");
    chk_auto_bound: assert property (wait_q <= LIM)
        else $error("auto mode made no trigger in time");
    chk_single_stays: assert property (
        mode_q == MD_SINGLE && !armed && !arm_wr |=> !armed)
        else $error("single mode rearmed without arm command");
    chk_rearm_works: assert property (
        acq_rearm && !armed && !ctrl_wr &&
        (mode_q == MD_AUTO || mode_q == MD_NORMAL) |=> armed)
        else $error("rearm request ignored");
    chk_unmapped_err: assert property (psel && penable && bad_addr |-> pslverr)
        else $error("no error on unmapped address");
    cover property (trig_pulse && trig_internal);
    cover property (trig_pulse && !trig_internal);
    cover property (acq_rearm && !armed && mode_q == MD_SINGLE);
endmodule
bind acquisition_trigger_logic acquisition_trigger_logic_assertions
    #(.AUTO_CYCLES(AUTO_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .acq_rearm(acq_rearm),
    .trig_pulse(trig_pulse), .trig_internal(trig_internal), .armed(armed));
`default_nettype wire

// >>> tb/acquisition_trigger_logic_tb_top.sv
// self-checking bench for the trigger block
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_logic_tb_top
    import trig_pkg::*;
;
    localparam int AUTO_N = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, trig_pulse, trig_internal, armed;
    logic ext_pin, mains_pin, acq_rearm;
    logic [3:0][SMP_W-1:0] ch;
    logic [32:0] exp_rd[$];
    logic exp_int[$];
    int n_fail = 0, checked = 0;
    initial forever #5 pclk = ~pclk;
    acquisition_trigger_logic #(.AUTO_CYCLES(AUTO_N)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analog_input_one(ch[0]),
        .analog_input_two(ch[1]), .analog_input_three(ch[2]),
        .analog_input_four(ch[3]), .external_trigger_pin(ext_pin),
        .mains_reference_source(mains_pin), .acq_rearm(acq_rearm),
        .trig_pulse(trig_pulse), .trig_internal(trig_internal),
        .armed(armed));
    sample_source_model ptr (.pclk(pclk), .trig_pulse(trig_pulse), .ch(ch),
        .ext_pin(ext_pin), .mains_pin(mains_pin), .acq_rearm(acq_rearm));
    task automatic cmp(input logic [32:0] got, want, input string what);
        checked++;
        if (got !== want) begin
            n_fail++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // results are judged where they appear, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            cmp({pslverr, prdata},
                exp_rd.size() ? exp_rd.pop_front() : {33{1'bx}}, "read");
        if (trig_pulse === 1'b1)
            cmp({32'h0, trig_internal}, exp_int.size() ?
                {32'h0, exp_int.pop_front()} : {33{1'bx}}, "trigger");
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        $display("ERROR %0t run timed out", $time);
        complete_run();
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit er = 0);
        exp_rd.push_back({er, e});
        apb(1'b0, a, 32'h0);
    endtask
    // random level kept on the same side of every threshold
    function automatic logic [7:0] rv(input logic [7:0] v);
        if (v == 8'hFF) return 8'hC0 + 8'($urandom % 64);
        if (v == 8'h00) return 8'($urandom % 65);
        return v;
    endfunction
    task automatic settle;
        int k;
        k = 0;
        repeat (20) @(posedge pclk);
        while (exp_int.size() != 0 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        cmp(33'(exp_int.size()), 33'h0, "missing trigger");
    endtask
    task automatic tcase(input logic [5:0] m, input logic [13:0] c,
        input logic [7:0] v0, v1, input int n, input bit e);
        wr(OFS_CTRL, 32'h47);
        ptr.drive(m, rv(v0), 8);
        wr(OFS_CTRL, {18'h0, c});
        wr(OFS_CMD, 32'h1);
        if (e) exp_int.push_back(1'b0);
        ptr.drive(m, rv(v1), n);
        ptr.drive(m, rv(v0), 8);
        settle();
    endtask
    initial begin
        logic [5:0] m;
        logic [31:0] w;
        void'($urandom(32'h73A4));
        repeat (20) @(posedge pclk);
        // reset leaves the block armed in auto mode, so it fires by itself
        exp_int.push_back(1'b1);
        presetn <= 1'b1;
        rd(OFS_CTRL, {18'h0, CTRL_RST});
        rd(OFS_LEVEL, {8'h0, LEVEL_RST});
        rd(OFS_WIDTH, {8'h0, WIDTH_RST});
        rd(OFS_DELAY, {8'h0, DELAY_RST});
        rd(OFS_CMD, 32'h0);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_STATUS, 32'hFF);
        rd(OFS_STATUS, 32'h6);
        rd(8'h18, 32'h0, 1);
        w = $urandom;
        wr(OFS_WIDTH, w);
        rd(OFS_WIDTH, {8'h0, w[23:0]});
        wr(OFS_WIDTH, 32'h10);
        for (int s = 0; s < 7; s++) begin
            m = (s == 6) ? 6'h0F : 6'(1 << s);
            tcase(~m, 14'(32'h40 + (s << 3)), 8'h00, 8'hFF, 8, 0);
            tcase(m, 14'(32'h40 + (s << 3)), 8'h00, 8'hFF, 8, 1);
        end
        tcase(6'h01, 14'h0042, 8'h00, 8'hFF, 30, 1);
        tcase(6'h01, 14'h0042, 8'h00, 8'hFF, 5, 0);
        tcase(6'h01, 14'h0242, 8'h00, 8'hFF, 5, 1);
        tcase(6'h01, 14'h0642, 8'h00, 8'hFF, 5, 1);
        tcase(6'h01, 14'h0044, 8'h00, 8'h80, 4, 1);
        tcase(6'h01, 14'h0044, 8'h00, 8'hFF, 4, 0);
        tcase(6'h01, 14'h1044, 8'hFF, 8'h80, 4, 1);
        tcase(6'h01, 14'h0046, 8'h00, 8'hFF, 30, 1);
        tcase(6'h01, 14'h0446, 8'hFF, 8'h00, 30, 1);
        tcase(6'h01, 14'h0245, 8'h00, 8'hFF, 4, 1);
        tcase(6'h01, 14'h0045, 8'h00, 8'hFF, 4, 0);
        tcase(6'h01, 14'h0443, 8'hFF, 8'h00, 4, 1);
        wr(OFS_CTRL, 32'h47);
        wr(OFS_CTRL, 32'h41);
        wr(OFS_CMD, 32'h1);
        ptr.drive(6'h10, 8'hFF, 4);
        ptr.drive(6'h10, 8'h00, 2);
        ptr.drive(6'h01, 8'hFF, 4);
        ptr.drive(6'h01, 8'h00, 30);
        exp_int.push_back(1'b0);
        ptr.drive(6'h01, 8'hFF, 8);
        ptr.drive(6'h01, 8'h00, 4);
        settle();
        wr(OFS_DELAY, 32'h2);
        wr(OFS_CTRL, 32'h47);
        wr(OFS_CTRL, 32'h841);
        wr(OFS_CMD, 32'h1);
        for (int i = 0; i < 2; i++) begin
            ptr.drive(6'h10, 8'hFF, 4);
            ptr.drive(6'h10, 8'h00, 4);
            if (i == 1) exp_int.push_back(1'b0);
            ptr.drive(6'h01, 8'hFF, 8);
            ptr.drive(6'h01, 8'h00, 8);
        end
        settle();
        ptr.rearm_dly = 10;
        ptr.rearm_en = 1'b1;
        wr(OFS_CTRL, 32'h0);
        exp_int.push_back(1'b1);
        exp_int.push_back(1'b1);
        wr(OFS_CMD, 32'h1);
        settle();
        wr(OFS_CTRL, 32'h47);
        ptr.rearm_dly = 1;
        wr(OFS_CTRL, 32'h80);
        wr(OFS_CMD, 32'h1);
        exp_int.push_back(1'b0);
        repeat (2) begin
            ptr.drive(6'h01, 8'hFF, 8);
            ptr.drive(6'h01, 8'h00, 8);
        end
        settle();
        cmp({32'h0, armed}, 33'h0, "single armed");
        wr(OFS_CMD, 32'h1);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_CMD, 32'h2);
        rd(OFS_STATUS, 32'h1);
        ptr.rearm_en = 1'b0;
        complete_run();
    end
endmodule
`default_nettype wire

// >>> tb/sample_source_model.sv
// front end samples, pins and acquisition controller facing the block
`timescale 1ns/1ps
`default_nettype none
module sample_source_model
    import trig_pkg::*;
(
    input wire logic pclk,
    input wire logic trig_pulse,
    output logic [3:0][SMP_W-1:0] ch,
    output logic ext_pin,
    output logic mains_pin,
    output var logic acq_rearm = 1'b0
);
    logic [5:0][SMP_W-1:0] val = '0;
    bit rearm_en = 1'b0;
    int rearm_dly = 1;
    int wait_n = 0;
    assign ch = val[3:0];
    assign ext_pin = val[4][SMP_W-1];
    assign mains_pin = val[5][SMP_W-1];
    // holds one level on every masked input for n cycles
    task automatic drive(input logic [5:0] m, input logic [7:0] v, input int n);
        logic [5:0][SMP_W-1:0] nv;
        @(posedge pclk);
        nv = val;
        for (int i = 0; i < 6; i++)
            if (m[i]) nv[i] = v;
        val <= nv;
        repeat (n - 1) @(posedge pclk);
    endtask
    // controller answers promptly or slowly, as the bench sets the delay
    always @(posedge pclk) begin
        acq_rearm <= !(trig_pulse === 1'b1 && rearm_en) && wait_n == 1;
        if (trig_pulse === 1'b1 && rearm_en)
            wait_n <= rearm_dly;
        else if (wait_n > 0)
            wait_n <= wait_n - 1;
    end
endmodule
`default_nettype wire
